// ==== hdl/mdbap_core.sv ====
module mdbap_core
  import mdbap_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear_n,
  input wire mdbap_bus_type bus,
  input wire logic [7:0] data_in,
  input wire logic unit_number_bit0,
  input wire logic unit_number_bit1,
  input wire logic overflow_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic [7:0] x_reg,
  output logic [7:0] y_reg,
  output logic [7:0] z_reg,
  output logic [7:0] ctrl_reg,
  output logic [1:0] seq_count,
  output logic shift_pulse
);
  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
    logic [7:0] ctrl;
    logic [7:0] dout;
    logic oe;
    logic strobe_prev;
  } mdbap_regs_type;

  mdbap_regs_type state_q, state_d;
  logic [1:0] seq_q, seq_d;
  logic shift_raw;
  logic shift_q;
  logic selected;
  logic matched;
  logic strobe_edge;
  logic [1:0] sel;
  logic [7:0] status_byte;

  function automatic logic [1:0] count_field(input logic [7:0] c);
    count_field = c[CTRL_COUNT_LSB +: 2];
  endfunction

  mdbap_prescaler u_presc (
    .clk(clk),
    .reset_n(reset_n),
    .clear_n(clear_n),
    .prescale_on(state_q.ctrl[CTRL_PRESCALE_BIT]),
    .unit_count(count_field(state_q.ctrl)),
    .shift_pulse(shift_raw)
  );

  assign sel = {bus.reg_sel_bit1, bus.reg_sel_bit0};
  assign selected = bus.enable && bus.reg_sel_bit2;
  assign matched = seq_q == {unit_number_bit1, unit_number_bit0};
  assign strobe_edge = bus.access_strobe && !state_q.strobe_prev;
  assign status_byte = {7'h00, overflow_in} << STATUS_OVF_BIT;

  always_comb begin
    state_d = state_q;
    seq_d = seq_q;
    state_d.strobe_prev = bus.access_strobe;
    state_d.oe = selected && bus.read_sel && matched;
    unique case (sel)
      SEL_X: state_d.dout = state_q.x;
      SEL_Z: state_d.dout = state_q.z;
      SEL_Y: state_d.dout = state_q.y;
      SEL_CTRL: state_d.dout = status_byte;
    endcase
    if (selected && strobe_edge) begin
      if (!bus.read_sel && matched) begin
        unique case (sel)
          SEL_X: state_d.x = data_in;
          SEL_Z: state_d.z = data_in;
          SEL_Y: state_d.y = data_in;
          SEL_CTRL: state_d.ctrl = data_in;
        endcase
      end
      // Every unit steps, so the cascade walks from top to bottom
      if (sel != SEL_CTRL) begin
        seq_d = seq_q + 2'h1;
      end
      if (sel == SEL_CTRL && !bus.read_sel && data_in[CTRL_SEQ_CLEAR_BIT]) begin
        seq_d = 2'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '{x: REG_RESET, y: REG_RESET, z: REG_RESET, ctrl: CTRL_RESET,
                   dout: REG_RESET, oe: 1'b0, strobe_prev: 1'b0};
      shift_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_raw;
    end
  end

  always_ff @(posedge clk or negedge reset_n or negedge clear_n) begin
    if (!reset_n || !clear_n) begin
      seq_q <= 2'h0;
    end else begin
      seq_q <= seq_d;
    end
  end

  assign data_out = state_q.dout;
  assign data_oe = state_q.oe;
  assign x_reg = state_q.x;
  assign y_reg = state_q.y;
  assign z_reg = state_q.z;
  assign ctrl_reg = state_q.ctrl;
  assign seq_count = seq_q;
  assign shift_pulse = shift_q;

  sequence s_write_x;
    selected && strobe_edge && !bus.read_sel && matched && sel == SEL_X;
  endsequence

  property p_float;
    @(posedge clk) disable iff (!reset_n) !selected |=> !data_oe;
  endproperty
  a_float: assert property (p_float) else $error("Bus driven while deselected");

  property p_read_x;
    @(posedge clk) disable iff (!reset_n)
      (selected && bus.read_sel && matched && sel == SEL_X) |=> data_oe && data_out == $past(state_q.x);
  endproperty
  a_read_x: assert property (p_read_x) else $error("X read wrong");

  property p_read_adv;
    @(posedge clk) disable iff (!reset_n || !clear_n)
      (selected && strobe_edge && bus.read_sel && sel != SEL_CTRL) |=> seq_q == $past(seq_q) + 2'h1;
  endproperty
  a_read_adv: assert property (p_read_adv) else $error("Counter not advanced");

  property p_load_x;
    @(posedge clk) disable iff (!reset_n) s_write_x |=> x_reg == $past(data_in);
  endproperty
  a_load_x: assert property (p_load_x) else $error("X not loaded");

  property p_no_strobe;
    @(posedge clk) disable iff (!reset_n)
      (selected && !bus.read_sel && !bus.access_strobe) |=> !data_oe && $stable(ctrl_reg) && $stable(x_reg);
  endproperty
  a_no_strobe: assert property (p_no_strobe) else $error("Write acted without strobe");

  property p_mismatch;
    @(posedge clk) disable iff (!reset_n) !matched |=> !data_oe;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("Unmatched unit responded");

  property p_status;
    @(posedge clk) disable iff (!reset_n)
      (selected && bus.read_sel && matched && sel == SEL_CTRL) |=> data_out[7:1] == 7'h00;
  endproperty
  a_status: assert property (p_status) else $error("Status upper bits set");

  property p_clear;
    @(posedge clk) !clear_n |-> seq_q == 2'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("Counter not cleared");

  property p_read_y;
    @(posedge clk) disable iff (!reset_n)
      (selected && bus.read_sel && matched && sel == SEL_Y) |=> data_oe && data_out == $past(state_q.y);
  endproperty
  a_read_y: assert property (p_read_y) else $error("Y read wrong");

  property p_read_z;
    @(posedge clk) disable iff (!reset_n)
      (selected && bus.read_sel && matched && sel == SEL_Z) |=> data_oe && data_out == $past(state_q.z);
  endproperty
  a_read_z: assert property (p_read_z) else $error("Z read wrong");

  property p_status_ovf;
    @(posedge clk) disable iff (!reset_n)
      (selected && bus.read_sel && matched && sel == SEL_CTRL)
      |=> data_oe && data_out[STATUS_OVF_BIT] == $past(overflow_in);
  endproperty
  a_status_ovf: assert property (p_status_ovf) else $error("Overflow flag wrong");

  sequence s_write_ctrl;
    selected && strobe_edge && !bus.read_sel && matched && sel == SEL_CTRL;
  endsequence

  property p_load_ctrl;
    @(posedge clk) disable iff (!reset_n) s_write_ctrl |=> ctrl_reg == $past(data_in);
  endproperty
  a_load_ctrl: assert property (p_load_ctrl) else $error("Control not loaded");

  property p_load_y;
    @(posedge clk) disable iff (!reset_n)
      (selected && strobe_edge && !bus.read_sel && matched && sel == SEL_Y) |=> y_reg == $past(data_in);
  endproperty
  a_load_y: assert property (p_load_y) else $error("Y not loaded");

  property p_load_z;
    @(posedge clk) disable iff (!reset_n)
      (selected && strobe_edge && !bus.read_sel && matched && sel == SEL_Z) |=> z_reg == $past(data_in);
  endproperty
  a_load_z: assert property (p_load_z) else $error("Z not loaded");

  property p_write_adv;
    @(posedge clk) disable iff (!reset_n || !clear_n)
      (selected && strobe_edge && !bus.read_sel && sel != SEL_CTRL) |=> seq_q == $past(seq_q) + 2'h1;
  endproperty
  a_write_adv: assert property (p_write_adv) else $error("Counter not advanced by write");

  property p_ctrl_clear;
    @(posedge clk) disable iff (!reset_n)
      (selected && strobe_edge && !bus.read_sel && sel == SEL_CTRL && data_in[CTRL_SEQ_CLEAR_BIT])
      |=> seq_q == 2'h0;
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear) else $error("Control clear missed");
endmodule // mdbap_core

// ==== hdl/mdbap_pkg.sv ====
package mdbap_pkg;
  localparam logic [1:0] SEL_X = 2'h0;
  localparam logic [1:0] SEL_Z = 2'h1;
  localparam logic [1:0] SEL_Y = 2'h2;
  localparam logic [1:0] SEL_CTRL = 2'h3;
  localparam int CTRL_PRESCALE_BIT = 7;
  localparam int CTRL_SEQ_CLEAR_BIT = 6;
  localparam int CTRL_COUNT_LSB = 4;
  localparam int STATUS_OVF_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] DIV_ONE_UNIT = 3'h1;
  localparam logic [2:0] DIV_TWO_UNITS = 3'h3;
  localparam logic [2:0] DIV_MANY_UNITS = 3'h7;

  typedef struct packed {
    logic enable;
    logic reg_sel_bit2;
    logic reg_sel_bit1;
    logic reg_sel_bit0;
    logic read_sel;
    logic access_strobe;
  } mdbap_bus_type;

  typedef struct packed {
    logic [2:0] div_cnt;
    logic shift_pulse;
  } mdbap_presc_type;
endpackage

// ==== hdl/mdbap_prescaler.sv ====
module mdbap_prescaler
  import mdbap_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear_n,
  input wire logic prescale_on,
  input wire logic [1:0] unit_count,
  output logic shift_pulse
);
  mdbap_presc_type state_q, state_d;
  logic [2:0] limit;

  always_comb begin
    unique case (unit_count)
      2'h0: limit = DIV_ONE_UNIT;
      2'h1: limit = DIV_TWO_UNITS;
      2'h2, 2'h3: limit = DIV_MANY_UNITS;
    endcase
    state_d = state_q;
    if (!prescale_on) begin
      state_d.div_cnt = 3'h0;
      state_d.shift_pulse = 1'b1;
    end else if (state_q.div_cnt >= limit) begin
      state_d.div_cnt = 3'h0;
      state_d.shift_pulse = 1'b1;
    end else begin
      state_d.div_cnt = state_q.div_cnt + 3'h1;
      state_d.shift_pulse = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n or negedge clear_n) begin
    if (!reset_n || !clear_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign shift_pulse = state_q.shift_pulse;

  property p_div_two;
    @(posedge clk) disable iff (!reset_n || !clear_n)
      (prescale_on && unit_count == 2'h0 && state_q.shift_pulse && $stable(unit_count))
      |=> !state_q.shift_pulse ##1 state_q.shift_pulse;
  endproperty
  a_div_two: assert property (p_div_two) else $error("Divide by two broken");

  property p_div_four;
    @(posedge clk) disable iff (!reset_n || !clear_n)
      (prescale_on && unit_count == 2'h1 && state_q.shift_pulse) ##1 (prescale_on && unit_count == 2'h1)[*3]
      |=> state_q.shift_pulse;
  endproperty
  a_div_four: assert property (p_div_four) else $error("Divide by four broken");

  property p_div_eight;
    @(posedge clk) disable iff (!reset_n || !clear_n)
      (prescale_on && unit_count[1] && state_q.shift_pulse) ##1 (prescale_on && unit_count[1])[*7]
      |=> state_q.shift_pulse;
  endproperty
  a_div_eight: assert property (p_div_eight) else $error("Divide by eight broken");

  property p_no_presc;
    @(posedge clk) disable iff (!reset_n || !clear_n)
      !prescale_on |=> state_q.shift_pulse;
  endproperty
  a_no_presc: assert property (p_no_presc) else $error("Shift not every clock");
endmodule // mdbap_prescaler

// ==== sim/mdbap_host_bus.sv ====
module mdbap_host_bus (
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output wire logic [7:0] host_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Host bus has pull-ups, so a floating bus reads all ones
  assign host_data = data_oe ? data_out : 8'hff;
endmodule // mdbap_host_bus

// ==== sim/tb_muldiv_bus_access_prescaler.sv ====
module tb_muldiv_bus_access_prescaler
  import mdbap_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clear_n = 1'b1;
  logic ovf = 1'b1;
  logic [1:0] strap = 2'h0;
  mdbap_bus_type bus = '0;
  logic [7:0] din = 8'h00;
  logic [7:0] dout, x, y, z, ctrl, rd_q;
  logic oe, sp;
  logic [1:0] seq;
  wire logic [7:0] hd;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [7:0] cv [5] = '{8'h00, 8'h80, 8'h90, 8'ha0, 8'hb0};
  int pe [5] = '{1, 2, 4, 8, 8};

  mdbap_core u_dut (.clk(clk), .reset_n(reset_n), .clear_n(clear_n), .bus(bus), .data_in(din),
    .unit_number_bit0(strap[0]), .unit_number_bit1(strap[1]), .overflow_in(ovf), .data_out(dout),
    .data_oe(oe), .x_reg(x), .y_reg(y), .z_reg(z), .ctrl_reg(ctrl), .seq_count(seq),
    .shift_pulse(sp));
  mdbap_host_bus u_host (.data_out(dout), .data_oe(oe), .host_data(hd));

  always #20 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      final_report();
    end
  end

  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Read data is taken one cycle after select, before the strobe
  task acc(input logic en, input logic [1:0] s, input logic rd, input logic [7:0] d, input logic stb);
    @(negedge clk);
    bus = '{en, 1'b1, s[1], s[0], rd, 1'b0};
    din = d;
    @(negedge clk);
    rd_q = hd;
    bus.access_strobe = stb;
    @(negedge clk);
    bus.access_strobe = 1'b0;
    @(negedge clk);
  endtask

  task per(input int e);
    int n;
    for (int i = 0; i < 20 && !sp; i++) @(negedge clk);
    @(negedge clk);
    n = 1;
    while (!sp && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n), 8'(e));
  endtask

  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk(hd, 8'hff);
    acc(1'b1, SEL_Z, 1'b0, 8'h5a, 1'b0);
    chk(z, 8'h00);
    chk(rd_q, 8'hff);
    acc(1'b0, SEL_X, 1'b0, 8'h33, 1'b1);
    chk(x, 8'h00);
    acc(1'b1, SEL_CTRL, 1'b0, 8'h00, 1'b1);
    chk({6'h00, seq}, 8'h00);
    acc(1'b1, SEL_X, 1'b0, 8'ha5, 1'b1);
    chk(x, 8'ha5);
    chk({6'h00, seq}, 8'h01);
    acc(1'b1, SEL_Y, 1'b0, 8'h77, 1'b1);
    chk(y, 8'h00);
    acc(1'b1, SEL_CTRL, 1'b0, 8'h40, 1'b1);
    chk({6'h00, seq}, 8'h00);
    chk(ctrl, 8'h00);
    acc(1'b1, SEL_CTRL, 1'b1, 8'h00, 1'b0);
    chk(rd_q, 8'h01);
    ovf = 1'b0;
    acc(1'b1, SEL_CTRL, 1'b1, 8'h00, 1'b0);
    chk(rd_q, 8'h00);
    acc(1'b1, SEL_X, 1'b1, 8'h00, 1'b1);
    chk(rd_q, 8'ha5);
    chk({6'h00, seq}, 8'h01);
    acc(1'b1, SEL_Z, 1'b1, 8'h00, 1'b1);
    chk(rd_q, 8'hff);
    acc(1'b1, SEL_CTRL, 1'b0, 8'h40, 1'b1);
    acc(1'b1, SEL_Y, 1'b0, 8'h77, 1'b1);
    acc(1'b1, SEL_CTRL, 1'b0, 8'h40, 1'b1);
    acc(1'b1, SEL_Z, 1'b0, 8'h3c, 1'b1);
    acc(1'b1, SEL_CTRL, 1'b0, 8'h40, 1'b1);
    acc(1'b1, SEL_Y, 1'b1, 8'h00, 1'b0);
    chk(rd_q, 8'h77);
    chk({6'h00, seq}, 8'h00);
    acc(1'b1, SEL_Z, 1'b1, 8'h00, 1'b1);
    chk(rd_q, 8'h3c);
    chk({6'h00, seq}, 8'h01);
    // Second unit in the cascade answers only on its own count
    strap = 2'h1;
    acc(1'b1, SEL_X, 1'b0, 8'h22, 1'b1);
    chk(x, 8'h22);
    acc(1'b1, SEL_X, 1'b0, 8'h33, 1'b1);
    chk(x, 8'h22);
    strap = 2'h0;
    clear_n = 1'b0;
    @(negedge clk);
    chk({6'h00, seq}, 8'h00);
    clear_n = 1'b1;
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, SEL_CTRL, 1'b0, cv[i], 1'b1);
      chk(ctrl, cv[i]);
      per(pe[i]);
    end
    final_report();
  end
endmodule // tb_muldiv_bus_access_prescaler
